/* eal_pkg.sv */
// Behaviour
// - Unit holds a 12-bit multiplier_quotient and a 5-bit step_counter.
// - Every arithmetic operation except normalize fetches the next word as operand or count.
// - cycle_hold stays asserted while an arithmetic operation runs, at least 7.8 us.
// - On completion active clears, hold_sync clears, 50 ns later cycle_hold releases.
// - multiplier_quotient acts as the low-order extension of the accumulator.
// - Shifts load complement of word bits 7-11; divide, multiply, normalize clear counter.
// - step_counter counts shifts and stops shifting at the required count.
// - Own instructions have bits 00-03 all ones and bit 11 one.
// - All own instructions take two words, except normalize which takes one.
// - Microinstructions combine, each running in its assigned logical sequence.
// - clear_accumulator clears the accumulator in sequence 1.
// - clear_both clears accumulator and quotient register in sequence 1; sequence 2 loads the cleared accumulator into the quotient register.
// - quotient_to_accumulator ORs multiplier_quotient into the accumulator.
// - load_quotient_from_accumulator clears, loads from accumulator, then clears accumulator.
// - count_to_accumulator ORs step_counter into the accumulator in sequence 2.
package eal_pkg;
	localparam real CLK_PERIOD_NS = 5.0;
	localparam real MIN_OP_US = 7.8;
	localparam real RELEASE_NS = 50.0;
	localparam int MIN_OP_CYCLES = int'($ceil(MIN_OP_US * 1000.0 / CLK_PERIOD_NS));
	localparam int RELEASE_CYCLES = int'($ceil(RELEASE_NS / CLK_PERIOD_NS));
	localparam int TMR_W = 11;
	localparam int DATA_W = 12;
	localparam int SC_W = 5;
	// Bit positions in memory_buffer; word bit 00 is vector bit 11
	localparam int MB_GRP_MSB = 11;
	localparam int MB_GRP_LSB = 8;
	localparam int MB_EAE_BIT = 0;
	localparam int MB_CLA_BIT = 7;
	localparam int MB_MQA_BIT = 6;
	localparam int MB_SCA_BIT = 5;
	localparam int MB_MQL_BIT = 4;
	localparam int MB_OP_MSB = 3;
	localparam int MB_OP_LSB = 1;
	localparam int MB_CNT_MSB = 4;
	localparam logic [3:0] GRP_ONES = 4'hf;
	localparam logic [4:0] SC_LAST_SHIFT = 5'h1f;
	localparam logic [4:0] SC_LAST_MULDIV = 5'h0b;
	localparam logic [11:0] AC_RESET = 12'h000;
	localparam logic [11:0] MQ_RESET = 12'h000;
	localparam logic [4:0] SC_RESET = 5'h00;
	typedef enum logic [2:0] {
		EAL_OP_NONE = 3'h0,
		EAL_OP_SCL = 3'h1,
		EAL_OP_MUY = 3'h2,
		EAL_OP_DVI = 3'h3,
		EAL_OP_NMI = 3'h4,
		EAL_OP_SHL = 3'h5,
		EAL_OP_ASR = 3'h6,
		EAL_OP_LSR = 3'h7
	} eal_op_t;
	typedef enum logic [2:0] {
		EAL_IDLE = 3'h0,
		EAL_SEQ1 = 3'h1,
		EAL_SEQ2 = 3'h2,
		EAL_FETCH = 3'h3,
		EAL_EXEC = 3'h4,
		EAL_DRAIN = 3'h5,
		EAL_RELEASE = 3'h6,
		EAL_RESUME = 3'h7
	} eal_state_t;
endpackage

/* eal_step_counter.sv */
`timescale 1ns/1ps
module eal_step_counter #(
	parameter int WIDTH = 5
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic load_cmp,
	input wire logic clear,
	input wire logic inc,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] count
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} eal_sc_state_t;
	eal_sc_state_t r_q;
	eal_sc_state_t r_d;
	always_comb begin
		r_d = r_q;
		if (load_cmp) begin
			r_d.cnt = ~din;
		end else if (clear) begin
			r_d.cnt = '0;
		end else if (inc) begin
			r_d.cnt = r_q.cnt + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
	assign count = r_q.cnt;
endmodule

/* eal_step_unit.sv */
`timescale 1ns/1ps
module eal_step_unit (
	input wire eal_pkg::eal_op_t op,
	input wire logic [11:0] ac,
	input wire logic [11:0] mq,
	input wire logic link,
	input wire logic [11:0] opr,
	input wire logic [4:0] sc,
	output logic [11:0] ac_n,
	output logic [11:0] mq_n,
	output logic link_n,
	output logic shifted,
	output logic last
);
	logic [12:0] sum;
	logic [12:0] rem;
	logic [12:0] diff;
	always_comb begin
		ac_n = ac;
		mq_n = mq;
		link_n = link;
		shifted = 1'b1;
		last = 1'b1;
		sum = {1'b0, ac} + (mq[0] ? {1'b0, opr} : 13'h0000);
		rem = {ac, mq[11]};
		diff = rem - {1'b0, opr};
		case (op)
			eal_pkg::EAL_OP_ASR: begin
				link_n = ac[11];
				{ac_n, mq_n} = {ac[11], ac, mq[11:1]};
				last = (sc == eal_pkg::SC_LAST_SHIFT);
			end
			eal_pkg::EAL_OP_LSR: begin
				link_n = 1'b0;
				{ac_n, mq_n} = {1'b0, ac, mq[11:1]};
				last = (sc == eal_pkg::SC_LAST_SHIFT);
			end
			eal_pkg::EAL_OP_SHL: begin
				{link_n, ac_n, mq_n} = {ac, mq, 1'b0};
				last = (sc == eal_pkg::SC_LAST_SHIFT);
			end
			eal_pkg::EAL_OP_MUY: begin
				link_n = 1'b0;
				{ac_n, mq_n} = {sum, mq[11:1]};
				last = (sc == eal_pkg::SC_LAST_MULDIV);
			end
			eal_pkg::EAL_OP_DVI: begin
				if (sc == 5'h00 && ac >= opr) begin
					// Quotient would not fit: flag in link, operands untouched
					link_n = 1'b1;
					shifted = 1'b0;
				end else begin
					link_n = 1'b0;
					ac_n = rem >= {1'b0, opr} ? diff[11:0] : rem[11:0];
					mq_n = {mq[10:0], rem >= {1'b0, opr}};
					last = (sc == eal_pkg::SC_LAST_MULDIV);
				end
			end
			eal_pkg::EAL_OP_NMI: begin
				if (ac[11] != ac[10] || {ac, mq} == 24'h000000 || sc == eal_pkg::SC_LAST_SHIFT) begin
					shifted = 1'b0;
				end else begin
					{link_n, ac_n, mq_n} = {ac, mq, 1'b0};
					last = 1'b0;
				end
			end
			default: begin
				shifted = 1'b0;
			end
		endcase
	end
endmodule

/* eal_core.sv */
`timescale 1ns/1ps
module eal_core (
	input wire logic clock,
	input wire logic srst,
	input wire logic instr_valid,
	input wire logic operand_valid,
	input wire logic [11:0] memory_buffer,
	input wire logic [11:0] acc_in,
	input wire logic link_in,
	input wire logic time_pulse_five,
	output logic [11:0] acc_out,
	output logic link_out,
	output logic acc_write,
	output logic [11:0] multiplier_quotient,
	output logic [4:0] step_counter,
	output logic fetch_req,
	output logic ext_arith_active,
	output logic hold_sync,
	output logic cycle_hold,
	output logic time_state_one_set
);
	typedef struct packed {
		eal_pkg::eal_state_t st;
		eal_pkg::eal_op_t op;
		logic clear_accumulator;
		logic quotient_to_accumulator;
		logic count_to_accumulator;
		logic load_quotient_from_accumulator;
		logic [11:0] ac;
		logic link;
		logic [11:0] mq;
		logic [11:0] opr;
		logic acc_write;
		logic fetch_req;
		logic active;
		logic hold_sync;
		logic cycle_hold;
		logic ts1_set;
		logic [eal_pkg::TMR_W-1:0] tmr;
	} eal_core_state_t;

	eal_core_state_t r_q;
	eal_core_state_t r_d;

	logic sc_load_cmp;
	logic sc_clear;
	logic sc_inc;
	logic [4:0] sc_val;
	logic [11:0] st_ac;
	logic [11:0] st_mq;
	logic st_link;
	logic st_shifted;
	logic st_last;

	function automatic logic is_eae(input logic [11:0] mb);
		is_eae = mb[eal_pkg::MB_GRP_MSB:eal_pkg::MB_GRP_LSB] == eal_pkg::GRP_ONES
			&& mb[eal_pkg::MB_EAE_BIT];
	endfunction

	function automatic eal_pkg::eal_op_t op_of(input logic [11:0] mb);
		op_of = eal_pkg::eal_op_t'(mb[eal_pkg::MB_OP_MSB:eal_pkg::MB_OP_LSB]);
	endfunction

	function automatic logic is_arith(input eal_pkg::eal_op_t op);
		is_arith = op != eal_pkg::EAL_OP_NONE && op != eal_pkg::EAL_OP_SCL;
	endfunction

	eal_step_counter #(
		.WIDTH(eal_pkg::SC_W)
	) u_sc (
		.clock(clock),
		.srst(srst),
		.load_cmp(sc_load_cmp),
		.clear(sc_clear),
		.inc(sc_inc),
		.din(memory_buffer[eal_pkg::MB_CNT_MSB:0]),
		.count(sc_val)
	);

	eal_step_unit u_step (
		.op(r_q.op),
		.ac(r_q.ac),
		.mq(r_q.mq),
		.link(r_q.link),
		.opr(r_q.opr),
		.sc(sc_val),
		.ac_n(st_ac),
		.mq_n(st_mq),
		.link_n(st_link),
		.shifted(st_shifted),
		.last(st_last)
	);

	always_comb begin
		r_d = r_q;
		r_d.acc_write = 1'b0;
		r_d.ts1_set = 1'b0;
		sc_load_cmp = 1'b0;
		sc_clear = 1'b0;
		sc_inc = 1'b0;
		// Minimum-time counter runs only while an operation is active
		if (r_q.active && r_q.tmr != eal_pkg::TMR_W'(eal_pkg::MIN_OP_CYCLES)) begin
			r_d.tmr = r_q.tmr + 1'b1;
		end
		case (r_q.st)
			eal_pkg::EAL_IDLE: begin
				// Decoded instruction arrives from the processor's decode stage
				if (instr_valid && is_eae(memory_buffer)) begin
					r_d.op = op_of(memory_buffer);
					r_d.clear_accumulator = memory_buffer[eal_pkg::MB_CLA_BIT];
					r_d.quotient_to_accumulator = memory_buffer[eal_pkg::MB_MQA_BIT];
					r_d.count_to_accumulator = memory_buffer[eal_pkg::MB_SCA_BIT];
					r_d.load_quotient_from_accumulator = memory_buffer[eal_pkg::MB_MQL_BIT];
					r_d.ac = acc_in;
					r_d.link = link_in;
					r_d.tmr = '0;
					r_d.st = eal_pkg::EAL_SEQ1;
					if (is_arith(op_of(memory_buffer))) begin
						r_d.active = 1'b1;
						r_d.hold_sync = 1'b1;
						r_d.cycle_hold = 1'b1;
					end
				end
			end
			eal_pkg::EAL_SEQ1: begin
				// Logical sequence 1: the clearing steps
				if (r_q.clear_accumulator) begin
					r_d.ac = 12'h000;
				end
				if (r_q.load_quotient_from_accumulator) begin
					r_d.mq = 12'h000;
				end
				r_d.st = eal_pkg::EAL_SEQ2;
			end
			eal_pkg::EAL_SEQ2: begin
				// Logical sequence 2: the loading steps, all on the sequence-1 results
				if (r_q.load_quotient_from_accumulator) begin
					r_d.mq = r_q.ac;
				end
				r_d.ac = (r_q.load_quotient_from_accumulator ? 12'h000 : r_q.ac)
					| (r_q.quotient_to_accumulator ? r_q.mq : 12'h000)
					| (r_q.count_to_accumulator ? {7'h00, sc_val} : 12'h000);
				r_d.acc_write = 1'b1;
				if (r_q.op == eal_pkg::EAL_OP_NMI) begin
					// Normalize is one word: no operand fetch
					sc_clear = 1'b1;
					r_d.st = eal_pkg::EAL_EXEC;
				end else begin
					r_d.fetch_req = 1'b1;
					r_d.st = eal_pkg::EAL_FETCH;
				end
			end
			eal_pkg::EAL_FETCH: begin
				if (operand_valid) begin
					r_d.opr = memory_buffer;
					r_d.fetch_req = 1'b0;
					case (r_q.op)
						eal_pkg::EAL_OP_ASR,
						eal_pkg::EAL_OP_LSR,
						eal_pkg::EAL_OP_SHL,
						eal_pkg::EAL_OP_SCL: begin
							sc_load_cmp = 1'b1;
						end
						eal_pkg::EAL_OP_MUY,
						eal_pkg::EAL_OP_DVI: begin
							sc_clear = 1'b1;
						end
						default: begin
						end
					endcase
					if (is_arith(r_q.op)) begin
						r_d.st = eal_pkg::EAL_EXEC;
					end else begin
						// Second word of a load-only or count-load instruction is consumed
						r_d.st = eal_pkg::EAL_IDLE;
					end
				end
			end
			eal_pkg::EAL_EXEC: begin
				r_d.ac = st_ac;
				r_d.mq = st_mq;
				r_d.link = st_link;
				sc_inc = st_shifted;
				if (st_last) begin
					r_d.st = eal_pkg::EAL_DRAIN;
				end
			end
			eal_pkg::EAL_DRAIN: begin
				// Hold the processor for at least the documented operation time
				if (r_q.tmr == eal_pkg::TMR_W'(eal_pkg::MIN_OP_CYCLES)) begin
					r_d.acc_write = 1'b1;
					r_d.active = 1'b0;
					r_d.hold_sync = 1'b0;
					r_d.tmr = '0;
					r_d.st = eal_pkg::EAL_RELEASE;
				end
			end
			eal_pkg::EAL_RELEASE: begin
				r_d.tmr = r_q.tmr + 1'b1;
				if (r_q.tmr == eal_pkg::TMR_W'(eal_pkg::RELEASE_CYCLES - 1)) begin
					r_d.cycle_hold = 1'b0;
					r_d.st = eal_pkg::EAL_RESUME;
				end
			end
			eal_pkg::EAL_RESUME: begin
				// Next time pulse five restarts the processor in time state one
				if (time_pulse_five) begin
					r_d.ts1_set = 1'b1;
					r_d.st = eal_pkg::EAL_IDLE;
				end
			end
			default: begin
				r_d.st = eal_pkg::EAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			r_q <= '0;
			r_q.st <= eal_pkg::EAL_IDLE;
			r_q.op <= eal_pkg::EAL_OP_NONE;
			r_q.ac <= eal_pkg::AC_RESET;
			r_q.mq <= eal_pkg::MQ_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	assign acc_out = r_q.ac;
	assign link_out = r_q.link;
	assign acc_write = r_q.acc_write;
	assign multiplier_quotient = r_q.mq;
	assign step_counter = sc_val;
	assign fetch_req = r_q.fetch_req;
	assign ext_arith_active = r_q.active;
	assign hold_sync = r_q.hold_sync;
	assign cycle_hold = r_q.cycle_hold;
	assign time_state_one_set = r_q.ts1_set;
endmodule

/* eal_core_monitor.sv */
`timescale 1ns/1ps
module eal_core_monitor (
	input wire logic clock,
	input wire logic srst,
	input wire logic instr_valid,
	input wire logic operand_valid,
	input wire logic [11:0] memory_buffer,
	input wire logic [11:0] acc_in,
	input wire logic link_in,
	input wire logic time_pulse_five,
	input wire logic [11:0] acc_out,
	input wire logic link_out,
	input wire logic acc_write,
	input wire logic [11:0] multiplier_quotient,
	input wire logic [4:0] step_counter,
	input wire logic fetch_req,
	input wire logic ext_arith_active,
	input wire logic hold_sync,
	input wire logic cycle_hold,
	input wire logic time_state_one_set
);
	localparam int MIN_ACT = 1560;
	int act_n;
	logic own;
	logic idle;
	assign own = memory_buffer[11:8] == 4'hf && memory_buffer[0];
	assign idle = !fetch_req && !cycle_hold && !acc_write;
	// Length of the current active stretch
	always_ff @(posedge clock) begin
		if (srst || !ext_arith_active) begin
			act_n <= 0;
		end else begin
			act_n <= act_n + 1;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	a_hold_on_take: assert property (instr_valid && own && idle && memory_buffer[3:1] >= 3'h2
		|=> ext_arith_active && hold_sync && cycle_hold) else $error("hold not raised");
	a_active_holds: assert property (ext_arith_active |-> hold_sync && cycle_hold)
		else $error("active without hold");
	a_active_min_time: assert property ($fell(ext_arith_active) |-> act_n >= MIN_ACT)
		else $error("operation too short");
	a_end_clears_sync: assert property ($fell(ext_arith_active) |-> acc_write && !hold_sync)
		else $error("end without sync clear");
	a_release_delay: assert property ($fell(hold_sync) |-> cycle_hold[*8] ##[1:3] !cycle_hold)
		else $error("release delay wrong");
	a_resume_pulse: assert property (time_state_one_set |-> !cycle_hold && $past(time_pulse_five))
		else $error("resume without pulse");
	a_fetch_waits: assert property (fetch_req && !operand_valid |=> fetch_req)
		else $error("fetch dropped");
	a_foreign_ignored: assert property (instr_valid && !own && idle
		|=> !ext_arith_active ##1 !acc_write ##1 !fetch_req) else $error("foreign word taken");
endmodule
bind eal_core eal_core_monitor u_mon (.clock, .srst, .instr_valid, .operand_valid, .memory_buffer, .acc_in,
	.link_in, .time_pulse_five, .acc_out, .link_out, .acc_write, .multiplier_quotient, .step_counter,
	.fetch_req, .ext_arith_active, .hold_sync, .cycle_hold, .time_state_one_set);

/* eal_cpu_model.sv */
`timescale 1ns/1ps
module eal_cpu_model (
	input wire logic clock,
	input wire logic srst,
	input wire logic acc_write,
	input wire logic [11:0] acc_out,
	input wire logic link_out,
	input wire logic ld,
	input wire logic [11:0] ldv,
	output logic [11:0] acc_in,
	output logic link_in,
	output logic time_pulse_five
);
	logic [3:0] tp_q;
	assign time_pulse_five = tp_q == 4'hf;
	always_ff @(posedge clock) begin
		if (srst) begin
			tp_q <= 4'h0;
			acc_in <= 12'h000;
			link_in <= 1'b0;
		end else begin
			tp_q <= tp_q + 4'h1;
			if (ld) begin
				acc_in <= ldv;
			end else if (acc_write) begin
				acc_in <= acc_out;
				link_in <= link_out;
			end
		end
	end
endmodule

/* test_extended_arith_load_control.sv */
`timescale 1ns/1ps
module test_extended_arith_load_control;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic instr_valid = 1'b0;
	logic operand_valid = 1'b0;
	logic ld = 1'b0;
	logic [11:0] memory_buffer = 12'h000;
	logic [11:0] ldv = 12'h000;
	logic [11:0] acc_in, acc_out, multiplier_quotient;
	logic [4:0] step_counter;
	logic link_in, time_pulse_five, link_out, acc_write, fetch_req;
	logic ext_arith_active, hold_sync, cycle_hold, time_state_one_set;
	int num_errors = 0;
	int n_compared = 0;
	int held = 0;
	int fetched = 0;
	always #2.5 clock = ~clock;
	eal_core u_dut (.clock, .srst, .instr_valid, .operand_valid, .memory_buffer, .acc_in, .link_in,
		.time_pulse_five, .acc_out, .link_out, .acc_write, .multiplier_quotient, .step_counter,
		.fetch_req, .ext_arith_active, .hold_sync, .cycle_hold, .time_state_one_set);
	eal_cpu_model u_cpu (.clock, .srst, .acc_write, .acc_out, .link_out, .ld, .ldv, .acc_in, .link_in,
		.time_pulse_five);
	always @(negedge clock) begin
		held += int'(cycle_hold === 1'b1);
		fetched += int'(fetch_req === 1'b1);
	end
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic test_done();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Loads the processor accumulator, then issues one instruction and, except for normalize, its second word
	task automatic run(input logic [11:0] w, input logic [11:0] opnd, input logic [11:0] ac);
		int n;
		n = 0;
		@(posedge clock);
		ld <= 1'b1;
		ldv <= ac;
		@(posedge clock);
		ld <= 1'b0;
		instr_valid <= 1'b1;
		memory_buffer <= w;
		@(posedge clock);
		instr_valid <= 1'b0;
		if (w[3:1] != 3'h4) begin
			while (fetch_req !== 1'b1 && n < 40) begin
				@(negedge clock);
				n++;
			end
			chk("fetch", 12'h001, 12'(fetch_req === 1'b1));
			@(posedge clock);
			operand_valid <= 1'b1;
			memory_buffer <= opnd;
			@(posedge clock);
			operand_valid <= 1'b0;
		end
		while (w[3:1] >= 3'h2 && time_state_one_set !== 1'b1 && n < 4000) begin
			@(negedge clock);
			n++;
		end
		chk("done", 12'h001, 12'(n < 4000));
		repeat (4) @(posedge clock);
	endtask
	task automatic t_load();
		run(12'hf11, 12'h000, 12'h005);
		chk("mq", 12'h005, multiplier_quotient);
		chk("ac", 12'h000, acc_out);
		run(12'hf41, 12'h000, 12'h0a0);
		chk("ac", 12'h0a5, acc_out);
		run(12'hfc1, 12'h000, 12'h0a0);
		chk("ac", 12'h005, acc_out);
		run(12'hf91, 12'h000, 12'h0f0);
		chk("ac", 12'h000, acc_out);
		chk("mq", 12'h000, multiplier_quotient);
		run(12'hf03, 12'h003, 12'h000);
		chk("sc", 12'h01c, 12'(step_counter));
		run(12'hfa1, 12'h000, 12'h300);
		chk("ac", 12'h01c, acc_out);
	endtask
	task automatic t_arith();
		int h;
		int f;
		run(12'hf11, 12'h000, 12'h001);
		h = held;
		run(12'hf0b, 12'h002, 12'h000);
		chk("mq", 12'h008, multiplier_quotient);
		chk("sc", 12'h000, 12'(step_counter));
		chk("hold", 12'h001, 12'(held - h >= 1560));
		run(12'hf11, 12'h000, 12'h003);
		run(12'hf05, 12'h005, 12'h000);
		chk("mq", 12'h00f, multiplier_quotient);
		chk("ac", 12'h000, acc_out);
		run(12'hf11, 12'h000, 12'h001);
		f = fetched;
		run(12'hf09, 12'h000, 12'h000);
		chk("ac", 12'h400, acc_out);
		chk("fetch", 12'h000, 12'(fetched - f));
		run(12'hf0d, 12'h000, 12'h800);
		chk("ac", 12'hc00, acc_out);
		run(12'hf0f, 12'h000, 12'hc00);
		chk("ac", 12'h600, acc_out);
		run(12'hf07, 12'h005, 12'h600);
		chk("link", 12'h001, 12'(link_out));
		run(12'hf11, 12'h000, 12'h011);
		run(12'hf07, 12'h005, 12'h000);
		chk("mq", 12'h003, multiplier_quotient);
		chk("ac", 12'h002, acc_out);
		chk("link", 12'h000, 12'(link_out));
	endtask
	// Reset in the middle of a multiply while it waits for its operand
	task automatic t_reset();
		@(posedge clock);
		instr_valid <= 1'b1;
		memory_buffer <= 12'hf05;
		@(posedge clock);
		instr_valid <= 1'b0;
		repeat (20) @(posedge clock);
		srst <= 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chk("flags", 12'h000, {6'h00, ext_arith_active, hold_sync, cycle_hold, fetch_req, acc_write,
			time_state_one_set});
		chk("ac", 12'h000, acc_out);
		chk("mq", 12'h000, multiplier_quotient);
		chk("sc", 12'h000, 12'(step_counter));
		run(12'hf11, 12'h000, 12'h007);
		chk("mq", 12'h007, multiplier_quotient);
	endtask
	task automatic t_foreign();
		int f;
		f = fetched + held;
		@(posedge clock);
		instr_valid <= 1'b1;
		memory_buffer <= 12'hf00;
		@(posedge clock);
		memory_buffer <= 12'hd11;
		@(posedge clock);
		instr_valid <= 1'b0;
		repeat (8) @(posedge clock);
		chk("ignored", 12'(f), 12'(fetched + held));
	endtask
	initial begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		t_load();
		t_arith();
		t_reset();
		t_foreign();
		test_done();
	end
	// Seven long operations need about 60 us
	initial begin
		#150000;
		num_errors++;
		test_done();
	end
endmodule
